// file: src/scdb_channel.sv
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Nine-bit shift register serialises and deserialises words.
// - Nine-bit async characters use shift bits 0 through 8.
// - Shift register has no address; data only via the data register.
// - Received serial bits land in the low 8/9 data register bits.
// - Transmit loads low 8/9 data bits into shift register, then out.
// - One 16-bit data register is both transmit and receive buffer.
// - Nine-bit buffer on wide channels, eight-bit buffer elsewhere.
// - Upper seven bits hold the operation clock division ratio; unused here, the divider is fixed at DIV_CYCLES.
// - Length select aligns 7/8/9-bit words at bit 0, any order.
// - Only async channel zero accepts nine-bit length.
// - Whole data register is read and written as one 16-bit word.
// - Low buffer bits also reachable through mode-specific alias.
// - Reset clears the whole data register to zero.
// - After reception, buffer bits above the length read zero.
// - Clocked mode with error control not zero may raise error IRQ.
module scdb_channel
   import scdb_pkg::*;
#(
   parameter bit WIDE_CHANNEL = 1'b1
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial pins
   input  wire logic        serialIn,
   output logic             serialOut,
   // Interrupt
   output logic             irq
);

   // ==================================================================
   // Register state
   logic [DATA_W-1:0]  dataReg_q;
   logic [DATA_W-1:0]  setup_q;
   logic [IRQ_W-1:0]   irqSt_q;
   logic [IRQ_W-1:0]   irqMsk_q;
   logic [SHIFT_W-1:0] shift_q;
   logic [BITCNT_W-1:0] bitCnt_q;
   logic [3:0]         divCnt_q;
   logic               txPend_q;
   logic               serialOut_q;
   scdb_state_t        state_q;
   scdb_cfg_t          cfg;

   logic               access;
   logic               wrEn;
   logic               wrData;
   logic               wrAlias;
   logic               tick;
   logic [BITCNT_W-1:0] wordLen;
   logic [SHIFT_W-1:0] bufMask;
   logic [SHIFT_W-1:0] rxWord;
   logic               txDone;
   logic               rxDone;
   logic               rxErr;
   logic [IRQ_W-1:0]   irqEvt;
   logic [SHIFT_W-1:0] rxAligned;
   logic               rxArmed_q;

   assign cfg.en   = setup_q[SET_ENABLE];
   assign cfg.eoc  = setup_q[SET_EOC];
   assign cfg.mode = scdb_mode_t'(setup_q[SET_MODE+1:SET_MODE]);
   assign cfg.dls  = {setup_q[SET_DLS_HI], setup_q[SET_DLS_LO]};

   // ==================================================================
   // APB decode: zero wait states, unmapped addresses answer with error
   assign access  = psel & penable;
   assign wrEn    = access & pwrite;
   assign wrData  = wrEn & (paddr == ADDR_DATA);
   assign wrAlias = wrEn & (paddr == ADDR_ALIAS);
   assign pready  = 1'b1;

   always_comb begin
      pslverr = 1'b0;
      if (access) begin
         case (paddr)
            ADDR_DATA, ADDR_ALIAS, ADDR_SETUP, ADDR_STATUS,
            ADDR_IRQST, ADDR_IRQMSK: pslverr = 1'b0;
            // Byte alias write to a stopped channel is refused below rather
            // than changing the buffer bits
            default: pslverr = 1'b1;
         endcase
         if (wrAlias && !cfg.en && pstrb != 4'hF) begin
            pslverr = 1'b1;
         end
      end
   end

   // ==================================================================
   // Word length; nine bits only on the wide channel in async mode
   always_comb begin
      if (cfg.dls == 2'b11 && WIDE_CHANNEL &&
          (cfg.mode == MODE_ASYNC_RX || cfg.mode == MODE_ASYNC_TX)) begin
         wordLen = 4'h9;
      end else if (cfg.dls == 2'b10) begin
         wordLen = 4'h7;
      end else begin
         wordLen = 4'h8;
      end
   end

   assign bufMask = (wordLen == 4'h9) ? 9'h1FF :
                    (wordLen == 4'h8) ? 9'h0FF : 9'h07F;

   // ==================================================================
   // Setup and interrupt mask registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         setup_q <= SETUP_RST;
      end else if (wrEn && paddr == ADDR_SETUP) begin
         setup_q <= pwdata[15:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         irqMsk_q <= MASK_RST;
      end else if (wrEn && paddr == ADDR_IRQMSK) begin
         irqMsk_q <= pwdata[IRQ_W-1:0];
      end
   end

   // ==================================================================
   // Data register: ratio bits and buffer bits
   always_comb begin
      rxWord = rxAligned & bufMask;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         dataReg_q <= DATA_RST;
      end else if (rxDone) begin
         dataReg_q[SHIFT_W-1:0] <= rxWord;
      end else if (wrData) begin
         dataReg_q <= pwdata[15:0];
      end else if (wrAlias && !(!cfg.en && pstrb != 4'hF)) begin
         dataReg_q[SHIFT_W-1:0] <= pwdata[SHIFT_W-1:0] & bufMask;
      end
   end

   // ==================================================================
   // Bit-rate enable from a divider
   always_ff @(posedge clk) begin
      if (!rstn) begin
         divCnt_q <= 4'h0;
      end else if (state_q == ST_IDLE || divCnt_q == DIV_LAST) begin
         divCnt_q <= 4'h0;
      end else begin
         divCnt_q <= divCnt_q + 4'h1;
      end
   end
   assign tick = (state_q != ST_IDLE) && (divCnt_q == DIV_LAST);

   // Writing the buffer in a transmit mode queues one word
   always_ff @(posedge clk) begin
      if (!rstn) begin
         txPend_q <= 1'b0;
      end else if ((wrData || wrAlias) && cfg.en &&
                   cfg.mode != MODE_ASYNC_RX) begin
         txPend_q <= 1'b1;
      end else if (state_q == ST_IDLE && txPend_q) begin
         txPend_q <= 1'b0;
      end
   end

   // ==================================================================
   // Receive arming: a start bit counts only once the line has been
   // seen high again, so a last data bit of zero is not a new start
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rxArmed_q <= 1'b1;
      end else if (rxDone) begin
         rxArmed_q <= 1'b0;
      end else if (serialIn) begin
         rxArmed_q <= 1'b1;
      end
   end

   // ==================================================================
   // Shift engine, LSB first; the shift register is internal only
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q  <= ST_IDLE;
         shift_q  <= '0;
         bitCnt_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (cfg.en && txPend_q) begin
                  // Only from idle, so a word in flight is never lost
                  shift_q  <= dataReg_q[SHIFT_W-1:0] & bufMask;
                  bitCnt_q <= wordLen;
                  state_q  <= ST_TX;
               end else if (cfg.en && cfg.mode == MODE_ASYNC_RX &&
                            !serialIn && rxArmed_q) begin
                  // Low level on the input marks a start bit
                  shift_q  <= '0;
                  bitCnt_q <= wordLen;
                  state_q  <= ST_RX;
               end
            end
            ST_TX: begin
               if (tick) begin
                  shift_q  <= {1'b0, shift_q[SHIFT_W-1:1]};
                  bitCnt_q <= bitCnt_q - 4'd1;
                  if (bitCnt_q == 4'd1) begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_RX: begin
               if (tick) begin
                  shift_q  <= {serialIn, shift_q[SHIFT_W-1:1]};
                  bitCnt_q <= bitCnt_q - 4'd1;
                  if (bitCnt_q == 4'd1) begin
                     state_q <= ST_IDLE;
                  end
               end else if (bitCnt_q == wordLen && 4'(SHIFT_W) != wordLen) begin
                  shift_q <= shift_q;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Received bits enter at the top; the word is taken together with its
   // last bit, else it would be stored one bit short, and realigned
   assign rxAligned = (wordLen == 4'h9) ? {serialIn, shift_q[8:1]} :
                      (wordLen == 4'h8) ? {1'b0, serialIn, shift_q[8:2]} :
                                          {2'b00, serialIn, shift_q[8:3]};

   assign txDone = (state_q == ST_TX) && tick && (bitCnt_q == 4'h1);
   assign rxDone = (state_q == ST_RX) && tick && (bitCnt_q == 4'h1);
   // Clocked mode with error control set flags a receive error when a transmit ends with another word queued
   assign rxErr  = rxDone ? 1'b0 :
                   (cfg.mode == MODE_CLOCKED) && cfg.eoc && txDone &&
                   txPend_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         serialOut_q <= 1'b1;
      end else if (state_q == ST_TX) begin
         serialOut_q <= shift_q[0];
      end else begin
         serialOut_q <= 1'b1;
      end
   end
   assign serialOut = serialOut_q;

   // ==================================================================
   // Interrupts: sticky, write one to clear, set wins over clear
   assign irqEvt = {rxErr, rxDone, txDone};

   always_ff @(posedge clk) begin
      if (!rstn) begin
         irqSt_q <= '0;
      end else begin
         for (int i = 0; i < IRQ_W; i++) begin
            if (irqEvt[i]) begin
               irqSt_q[i] <= 1'b1;
            end else if (wrEn && paddr == ADDR_IRQST && pwdata[i]) begin
               irqSt_q[i] <= 1'b0;
            end
         end
      end
   end
   assign irq = |(irqSt_q & irqMsk_q);

   // ==================================================================
   // Read mux
   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         ADDR_DATA:   prdata = {16'h0000, dataReg_q};
         ADDR_ALIAS:  prdata = {23'h000000, dataReg_q[SHIFT_W-1:0]};
         ADDR_SETUP:  prdata = {16'h0000, setup_q};
         ADDR_STATUS: prdata = {28'h0000000, txPend_q,
                                state_q == ST_RX, state_q == ST_TX, cfg.en};
         ADDR_IRQST:  prdata = {29'h00000000, irqSt_q};
         ADDR_IRQMSK: prdata = {29'h00000000, irqMsk_q};
         default:     prdata = 32'h0000_0000;
      endcase
   end

   // ==================================================================
   // Checks
   sequence txStart_s;
      state_q == ST_IDLE && cfg.en && txPend_q;
   endsequence

   sequence txEnd_s;
      state_q == ST_TX && tick && bitCnt_q == 4'h1;
   endsequence

   sequence rxEnd_s;
      state_q == ST_RX && tick && bitCnt_q == 4'h1;
   endsequence

   reset_clears_a: assert property (@(posedge clk)
      !rstn |=> dataReg_q == DATA_RST)
      else $error("data register not cleared by reset");

   ratio_kept_a: assert property (@(posedge clk) disable iff (!rstn)
      wrAlias |=> dataReg_q[15:9] == $past(dataReg_q[15:9]))
      else $error("alias write touched ratio bits");

   rx_upper_zero_a: assert property (@(posedge clk) disable iff (!rstn)
      rxDone |=> (dataReg_q[8:0] & ~$past(bufMask)) == 9'h000)
      else $error("bits above length not zero after receive");

   rx_store_a: assert property (@(posedge clk) disable iff (!rstn)
      rxEnd_s |=> dataReg_q[8:0] == ($past(rxAligned) & $past(bufMask))
                  && dataReg_q[15:9] == $past(dataReg_q[15:9]))
      else $error("received word not stored in buffer bits");

   tx_load_a: assert property (@(posedge clk) disable iff (!rstn)
      txStart_s |=> state_q == ST_TX
                    && shift_q == ($past(dataReg_q[8:0]) & $past(bufMask)))
      else $error("transmit word not loaded");

   tx_done_flag_a: assert property (@(posedge clk) disable iff (!rstn)
      txEnd_s |=> irqSt_q[IRQ_TXDONE])
      else $error("transmit end not flagged");

   idle_line_a: assert property (@(posedge clk) disable iff (!rstn)
      state_q != ST_TX |=> serialOut)
      else $error("serial output not idle high outside transmit");

   no_reload_a: assert property (@(posedge clk) disable iff (!rstn)
      state_q == ST_TX && !txDone |=> $stable(bitCnt_q) || tick
         || $past(tick))
      else $error("shift register reloaded mid word");

   shift_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      state_q == ST_TX && !tick |=> $stable(shift_q))
      else $error("shift register moved between bit steps");

   nine_bit_a: assert property (@(posedge clk) disable iff (!rstn)
      wordLen == 4'h9 |-> WIDE_CHANNEL
         && cfg.mode inside {MODE_ASYNC_RX, MODE_ASYNC_TX})
      else $error("nine bits outside async wide channel");

   full_write_a: assert property (@(posedge clk) disable iff (!rstn)
      wrData && !rxDone |=> dataReg_q == $past(pwdata[15:0]))
      else $error("16-bit write not stored");

   alias_refused_a: assert property (@(posedge clk) disable iff (!rstn)
      wrAlias && !cfg.en && pstrb != 4'hF && !rxDone
         |-> pslverr ##1 dataReg_q == $past(dataReg_q))
      else $error("byte alias write to stopped channel not refused");

   err_cause_a: assert property (@(posedge clk) disable iff (!rstn)
      rxErr |-> cfg.mode == MODE_CLOCKED && cfg.eoc)
      else $error("error irq without clocked mode and control");

   err_sticky_a: assert property (@(posedge clk) disable iff (!rstn)
      rxErr |=> irqSt_q[IRQ_RXERR])
      else $error("receive error not flagged");

endmodule

`default_nettype wire

// file: src/scdb_pkg.sv
package scdb_pkg;

   // ==================================================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_DATA   = 8'h00;
   localparam logic [7:0] ADDR_ALIAS  = 8'h04;
   localparam logic [7:0] ADDR_SETUP  = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_IRQST  = 8'h10;
   localparam logic [7:0] ADDR_IRQMSK = 8'h14;

   // ==================================================================
   // Field layout
   localparam int DATA_W     = 16;
   localparam int SHIFT_W    = 9;
   localparam int DIV_LSB    = 9;
   localparam int DIV_W      = 7;
   localparam int BITCNT_W   = 4;

   // Setup register bits
   localparam int SET_DLS_LO = 0;
   localparam int SET_DLS_HI = 1;
   localparam int SET_ENABLE = 4;
   localparam int SET_EOC    = 5;
   localparam int SET_MODE   = 8;
   localparam int SET_BIG9   = 12;

   // Interrupt status bits
   localparam int IRQ_TXDONE = 0;
   localparam int IRQ_RXDONE = 1;
   localparam int IRQ_RXERR  = 2;
   localparam int IRQ_W      = 3;

   // ==================================================================
   // Reset values
   localparam logic [15:0] DATA_RST  = 16'h0000;
   localparam logic [15:0] SETUP_RST = 16'h0007;
   localparam logic [2:0]  MASK_RST  = 3'h0;

   // Bit-rate divider: one shift step per DIV_CYCLES clocks
   localparam int          DIV_CYCLES = 4;
   localparam logic [3:0]  DIV_LAST   = 4'(DIV_CYCLES - 1);

   // ==================================================================
   // Types
   typedef enum logic [1:0] {
      MODE_CLOCKED, MODE_ASYNC_RX, MODE_ASYNC_TX, MODE_TWO_WIRE
   } scdb_mode_t;

   typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} scdb_state_t;

   typedef struct packed {
      logic        en;
      logic        eoc;
      scdb_mode_t  mode;
      logic [1:0]  dls;
   } scdb_cfg_t;

endpackage

// file: verification/scdb_channel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ==================================================================
// Bench for one serial channel data path
module scdb_channel_tb_top;
   import scdb_pkg::*;

   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        serialIn;
   logic        serialOut;
   logic        irq;
   logic [31:0] rdata;
   logic        lastErr;
   int          errors = 0;
   int          checked = 0;

   always #2.5 clk = ~clk;

   scdb_channel #(.WIDE_CHANNEL(1'b1)) u_dut (
      .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serialIn(serialIn), .serialOut(serialOut), .irq(irq));

   scdb_remote u_rem (.clk(clk), .serialOut(serialOut), .serialIn(serialIn));

   // ==================================================================
   // Checking and verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ==================================================================
   // APB master: request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdata   = prdata;
      lastErr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(rdata, exp);
   endtask

   // Polls the sticky status under a bounded count
   task automatic waitIrq(input int b);
      int k;
      k = 0;
      rdata = 32'h0;
      while (rdata[b] !== 1'b1 && k < 300) begin
         apb(1'b0, ADDR_IRQST, 32'h0, 4'h0);
         k++;
      end
      chk({31'h0, rdata[b]}, 32'h1);
   endtask

   // Irq is looked at half a cycle after a write, once the new state stands
   task automatic chkIrq(input logic e);
      @(negedge clk);
      chk({31'h0, irq}, {31'h0, e});
   endtask

   // ==================================================================
   // Tests
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rd(ADDR_DATA, 32'h0000_0000);
      rd(ADDR_SETUP, 32'h0000_0007);
      rd(ADDR_IRQMSK, 32'h0000_0000);
      rd(ADDR_IRQST, 32'h0000_0000);
      chk({30'h0, irq, serialOut}, 32'h1);
      apb(1'b0, 8'h18, 32'h0, 4'h0);
      chk({31'h0, lastErr}, 32'h1);
      // Whole word and its alias, channel stopped
      wr(ADDR_DATA, 32'h0000_ABCD);
      rd(ADDR_DATA, 32'h0000_ABCD);
      rd(ADDR_ALIAS, 32'h0000_01CD);
      apb(1'b1, ADDR_ALIAS, 32'h0000_0011, 4'h1);
      chk({31'h0, lastErr}, 32'h1);
      rd(ADDR_DATA, 32'h0000_ABCD);
      // Receive, 7-bit; setup keeps bit 2 set and 3, 6, 11 clear
      wr(ADDR_SETUP, 32'h0000_0116);
      wr(ADDR_ALIAS, 32'h0000_00FF);
      rd(ADDR_DATA, 32'h0000_AA7F);
      u_rem.send(9'h055, 7);
      waitIrq(IRQ_RXDONE);
      rd(ADDR_DATA, 32'h0000_AA55);
      chk({31'h0, irq}, 32'h0);
      wr(ADDR_IRQST, 32'h0000_0007);
      // Receive, 9-bit, only on the wide channel
      wr(ADDR_SETUP, 32'h0000_0117);
      u_rem.send(9'h1A5, 9);
      waitIrq(IRQ_RXDONE);
      rd(ADDR_DATA, 32'h0000_ABA5);
      wr(ADDR_IRQST, 32'h0000_0007);
      rd(ADDR_IRQST, 32'h0000_0000);
      // Transmit, two words back to back
      wr(ADDR_IRQMSK, 32'h0000_0001);
      wr(ADDR_SETUP, 32'h0000_0215);
      wr(ADDR_DATA, 32'h0000_00A5);
      wr(ADDR_DATA, 32'h0000_003C);
      waitIrq(IRQ_TXDONE);
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, u_rem.seen(9'h0A5, 8)}, 32'h1);
      wr(ADDR_IRQST, 32'h0000_0001);
      chkIrq(1'b0);
      waitIrq(IRQ_TXDONE);
      chk({31'h0, u_rem.seen(9'h03C, 8)}, 32'h1);
      wr(ADDR_IRQMSK, 32'h0000_0000);
      chkIrq(1'b0);
      wr(ADDR_IRQMSK, 32'h0000_0001);
      chkIrq(1'b1);
      wr(ADDR_IRQST, 32'h0000_0001);
      chkIrq(1'b0);
      rd(ADDR_IRQST, 32'h0000_0000);
      // Clocked mode, error control set, word queued as previous ends
      wr(ADDR_SETUP, 32'h0000_0034);
      wr(ADDR_DATA, 32'h0000_0081);
      wr(ADDR_DATA, 32'h0000_0042);
      waitIrq(IRQ_RXERR);
      give_verdict;
   end

   // Whole run is a few hundred cycles; this leaves ample margin
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      give_verdict;
   end
endmodule

`default_nettype wire

// file: verification/scdb_remote.sv
`timescale 1ns/1ps
`default_nettype none

// ==================================================================
// Remote serial device: drives the receive line, records the other
module scdb_remote (
   // Clock
   input  wire logic clk,
   // Serial pins seen from the far side
   input  wire logic serialOut,
   output logic      serialIn
);
   logic [63:0] hist;

   initial serialIn = 1'b1;

   // Newest sample in bit 0; long enough for one word plus slack
   always_ff @(posedge clk) begin
      hist <= {hist[62:0], serialOut};
   end

   // Start low, bits LSB first, stop high; 4 clocks a bit
   task automatic send(input logic [8:0] v, input int n);
      serialIn <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         serialIn <= v[i];
         repeat (4) @(posedge clk);
      end
      serialIn <= 1'b1;
      repeat (8) @(posedge clk);
   endtask

   // Phase of the bit clock is unknown, so every sampling offset is tried
   function automatic logic seen(input logic [8:0] v, input int n);
      logic ok;
      seen = 1'b0;
      for (int o = 0; o < 16; o++) begin
         ok = 1'b1;
         for (int i = 0; i < n; i++) begin
            if (hist[o + 4 * (n - 1 - i)] !== v[i])
               ok = 1'b0;
         end
         if (ok)
            seen = 1'b1;
      end
   endfunction
endmodule

`default_nettype wire
